// ### src/atsd_pkg.sv
// atsd_pkg: addresses, reset values, field layout and timing constants
// of the trim, swap-delay and dither register bank.
// assumes a serial register port with a 15-bit address and 8-bit data.
`default_nettype none

package atsd_pkg;

  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 8;
  localparam int DLY_W     = 5;
  localparam int DITH_W    = 3;
  localparam int N_INPUTS  = 4;
  localparam int OVL_CNT_W = 7;
  localparam int BIT_CNT_W = 5;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_TRIM_A = 15'h007e;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_B = 15'h007f;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_C = 15'h0080;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_D = 15'h0081;
  localparam logic [ADDR_W-1:0] ADDR_OVL    = 15'h009a;
  localparam logic [ADDR_W-1:0] ADDR_STEER  = 15'h009b;
  localparam logic [ADDR_W-1:0] ADDR_DITH   = 15'h009d;

  // reset values
  localparam logic [DATA_W-1:0] RST_TRIM  = 8'h00;
  localparam logic [DLY_W-1:0]  RST_OVL   = 5'h08;
  localparam logic [DLY_W-1:0]  RST_STEER = 5'h07;
  localparam logic [DITH_W-1:0] RST_DITH  = 3'h0;

  // dither field positions
  localparam int DITH_EN_BIT  = 0;
  localparam int DITH_AMP_BIT = 1;
  localparam int DITH_ERR_BIT = 2;

  // overlap length is base plus twice the delay field
  localparam logic [OVL_CNT_W-1:0] OVL_BASE = 7'h04;

  // serial frame: read flag, address, data
  localparam logic [BIT_CNT_W-1:0] HDR_BITS   = 5'h10;
  localparam logic [BIT_CNT_W-1:0] FRAME_BITS = 5'h18;
  localparam int                   RNW_POS    = 14;

  // register selector produced by the address decoder
  typedef enum logic [2:0] {
    ATSD_SEL_TRIM_A = 3'h0,
    ATSD_SEL_TRIM_B = 3'h1,
    ATSD_SEL_TRIM_C = 3'h2,
    ATSD_SEL_TRIM_D = 3'h3,
    ATSD_SEL_OVL    = 3'h4,
    ATSD_SEL_STEER  = 3'h5,
    ATSD_SEL_DITH   = 3'h6,
    ATSD_SEL_NONE   = 3'h7
  } atsd_sel_e;

  // swap sequencer states, gray along idle-active-done
  typedef enum logic [1:0] {
    ATSD_SW_IDLE   = 2'h0,
    ATSD_SW_ACTIVE = 2'h1,
    ATSD_SW_DONE   = 2'h3
  } atsd_swap_e;

endpackage : atsd_pkg

`default_nettype wire

// ### src/atsd_spi_slave.sv
// atsd_spi_slave: serial register port, mode 0, msb first.
// frame is 24 bits: read flag, 15-bit address, 8 data bits.
// assumes sclk and scs_n are synchronous to clk and much slower than it.
`default_nettype none

module atsd_spi_slave
  import atsd_pkg::*;
(
  input  wire logic              clk,     // system clock
  input  wire logic              srst,    // synchronous reset
  input  wire logic              sclk,    // serial clock pin
  input  wire logic              scs_n,   // chip select, active low
  input  wire logic              sdi,     // serial data in
  input  wire logic [DATA_W-1:0] rd_data, // read data for addr
  output logic                   sdo,     // serial data out
  output logic                   sdo_oe,  // sdo drive enable
  output logic                   wr_stb,  // one-cycle write pulse
  output logic [ADDR_W-1:0]      addr,    // latched address
  output logic [DATA_W-1:0]      wdata    // write data
);

  logic                 sclk_q, sclk_d;
  logic [BIT_CNT_W-1:0] cnt_q, cnt_d;
  logic [DATA_W*3-1:0]  shin_q, shin_d;
  logic [DATA_W-1:0]    shout_q, shout_d;
  logic [ADDR_W-1:0]    addr_q, addr_d;
  logic [DATA_W-1:0]    wdata_q, wdata_d;
  logic                 rnw_q, rnw_d;
  logic                 ld_q, ld_d;
  logic                 wr_q, wr_d;
  logic                 sdo_q, sdo_d;
  logic                 oe_q, oe_d;
  logic                 rise, fall;

  assign rise   = sclk & ~sclk_q & ~scs_n;
  assign fall   = ~sclk & sclk_q & ~scs_n;
  assign sdo    = sdo_q;
  assign sdo_oe = oe_q;
  assign wr_stb = wr_q;
  assign addr   = addr_q;
  assign wdata  = wdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // frame decode; bits past the 24th are ignored, no address streaming
  always_comb begin
    sclk_d  = sclk;
    cnt_d   = cnt_q;
    shin_d  = shin_q;
    shout_d = shout_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rnw_d   = rnw_q;
    ld_d    = 1'b0;
    wr_d    = 1'b0;
    sdo_d   = sdo_q;
    oe_d    = oe_q;
    if (scs_n) begin
      cnt_d = '0;
      oe_d  = 1'b0;
    end else if (rise && cnt_q != FRAME_BITS) begin
      shin_d = {shin_q[DATA_W*3-2:0], sdi};
      cnt_d  = cnt_q + 5'h01;
      if (cnt_q == HDR_BITS - 5'h01) begin
        addr_d = {shin_q[ADDR_W-2:0], sdi};
        rnw_d  = shin_q[RNW_POS];
        ld_d   = shin_q[RNW_POS];
      end
      if (cnt_q == FRAME_BITS - 5'h01 && !rnw_q) begin
        wdata_d = {shin_q[DATA_W-2:0], sdi};
        wr_d    = 1'b1;
      end
    end else if (fall && rnw_q && cnt_q >= HDR_BITS) begin
      // data changes on the falling edge so the host samples it on rise
      sdo_d   = shout_q[DATA_W-1];
      shout_d = {shout_q[DATA_W-2:0], 1'b0};
      oe_d    = 1'b1;
    end
    // read data is taken one cycle after the address settles
    if (ld_q) begin
      shout_d = rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_q  <= 1'b0;
      cnt_q   <= '0;
      shin_q  <= '0;
      shout_q <= '0;
      addr_q  <= '0;
      wdata_q <= '0;
      rnw_q   <= 1'b0;
      ld_q    <= 1'b0;
      wr_q    <= 1'b0;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      sclk_q  <= sclk_d;
      cnt_q   <= cnt_d;
      shin_q  <= shin_d;
      shout_q <= shout_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rnw_q   <= rnw_d;
      ld_q    <= ld_d;
      wr_q    <= wr_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
    end
  end

endmodule : atsd_spi_slave

`default_nettype wire

// ### src/atsd_swap_timer.sv
// atsd_swap_timer: times one background core swap: overlap window and
// the toggle of the steering select. counts converter clock cycles,
// which here are cycles of clk.
`default_nettype none

module atsd_swap_timer
  import atsd_pkg::*;
(
  input  wire logic             clk,            // converter clock
  input  wire logic             srst,           // synchronous reset
  input  wire logic             swap_start,     // swap request pulse
  input  wire logic [DLY_W-1:0] overlap_dly,    // overlap delay field
  input  wire logic [DLY_W-1:0] steer_dly,      // steering delay field
  output logic                  overlap_active, // both cores sample
  output logic                  steer_sel,      // steering select
  output logic                  busy            // swap in progress
);

  atsd_swap_e           st_q, st_d;
  logic [OVL_CNT_W-1:0] ovl_q, ovl_d;
  logic [DLY_W-1:0]     str_q, str_d;
  logic                 pend_q, pend_d;
  logic                 act_q, act_d;
  logic                 sel_q, sel_d;
  logic                 busy_q, busy_d;

  // busy is kept in its own flop so the top output comes straight from one
  assign overlap_active = act_q;
  assign steer_sel      = sel_q;
  assign busy           = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // delays are captured at start so a write mid-swap cannot tear it
  always_comb begin
    st_d   = st_q;
    ovl_d  = ovl_q;
    str_d  = str_q;
    pend_d = pend_q;
    act_d  = act_q;
    sel_d  = sel_q;
    unique case (st_q)
      ATSD_SW_IDLE: begin
        if (swap_start) begin
          st_d   = ATSD_SW_ACTIVE;
          act_d  = 1'b1;
          ovl_d  = OVL_BASE + {1'b0, overlap_dly, 1'b0} - 7'h01;
          str_d  = steer_dly;
          pend_d = 1'b1;
        end
      end
      ATSD_SW_ACTIVE: begin
        if (act_q) begin
          if (ovl_q == '0) act_d = 1'b0;
          else ovl_d = ovl_q - 7'h01;
        end
        if (pend_q) begin
          if (str_q == '0) begin
            sel_d  = ~sel_q;
            pend_d = 1'b0;
          end else begin
            str_d = str_q - 5'h01;
          end
        end
        if (!act_q && !pend_q) st_d = ATSD_SW_DONE;
      end
      ATSD_SW_DONE: begin
        st_d = ATSD_SW_IDLE;
      end
      // the unused code falls back to idle rather than hanging
      default: begin
        st_d = ATSD_SW_IDLE;
      end
    endcase
    busy_d = (st_d != ATSD_SW_IDLE);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q   <= ATSD_SW_IDLE;
      ovl_q  <= '0;
      str_q  <= '0;
      pend_q <= 1'b0;
      act_q  <= 1'b0;
      sel_q  <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      ovl_q  <= ovl_d;
      str_q  <= str_d;
      pend_q <= pend_d;
      act_q  <= act_d;
      sel_q  <= sel_d;
      busy_q <= busy_d;
    end
  end

endmodule : atsd_swap_timer

`default_nettype wire

// ### src/atsd_regs.sv
// atsd_regs: termination trim, swap delay and dither register bank
// behind the serial register port, with the swap timer it steers.
// assumes fuse values are stable from reset and that swap_start comes
// from the calibration engine as a one-cycle pulse.
`default_nettype none

module atsd_regs
  import atsd_pkg::*;
(
  input  wire logic              clk,                     // 100 MHz clock
  input  wire logic              srst,                    // sync reset
  input  wire logic              sclk,                    // serial clock
  input  wire logic              scs_n,                   // select, low
  input  wire logic              sdi,                     // serial in
  output logic                   sdo,                     // serial out
  output logic                   sdo_oe,                  // sdo enable
  input  wire logic [DATA_W-1:0] fuse_trim_a,             // fuse trim a
  input  wire logic [DATA_W-1:0] fuse_trim_b,             // fuse trim b
  input  wire logic [DATA_W-1:0] fuse_trim_c,             // fuse trim c
  input  wire logic [DATA_W-1:0] fuse_trim_d,             // fuse trim d
  input  wire logic              swap_start,              // swap pulse
  output logic [DATA_W-1:0]      input_a_term_trim,       // trim a
  output logic [DATA_W-1:0]      input_b_term_trim,       // trim b
  output logic [DATA_W-1:0]      input_c_term_trim,       // trim c
  output logic [DATA_W-1:0]      input_d_term_trim,       // trim d
  output logic                   dither_enable,           // dither on
  output logic                   dither_amplitude_select, // large dither
  output logic                   rounding_error_select,   // error to dc
  output logic                   swap_overlap_active,     // overlap window
  output logic                   steer_sel,               // steering select
  output logic                   swap_busy                // swap running
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the write and read paths
  function automatic atsd_sel_e reg_sel(input logic [ADDR_W-1:0] a);
    atsd_sel_e s;
    s = ATSD_SEL_NONE;
    unique case (a)
      ADDR_TRIM_A: s = ATSD_SEL_TRIM_A;
      ADDR_TRIM_B: s = ATSD_SEL_TRIM_B;
      ADDR_TRIM_C: s = ATSD_SEL_TRIM_C;
      ADDR_TRIM_D: s = ATSD_SEL_TRIM_D;
      ADDR_OVL:    s = ATSD_SEL_OVL;
      ADDR_STEER:  s = ATSD_SEL_STEER;
      ADDR_DITH:   s = ATSD_SEL_DITH;
      default:     s = ATSD_SEL_NONE;
    endcase
    return s;
  endfunction : reg_sel

  logic              wr_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rd_data;
  atsd_sel_e         sel;

  logic [DATA_W-1:0] fuse_w [N_INPUTS];
  logic [DATA_W-1:0] trim_q [N_INPUTS];
  logic [DATA_W-1:0] trim_d [N_INPUTS];
  logic              fuse_ld_q, fuse_ld_d;
  logic [DLY_W-1:0]  ovl_q, ovl_d;
  logic [DLY_W-1:0]  steer_q, steer_d;
  logic [DITH_W-1:0] dith_q, dith_d;

  assign sel       = reg_sel(addr);
  assign fuse_w[0] = fuse_trim_a;
  assign fuse_w[1] = fuse_trim_b;
  assign fuse_w[2] = fuse_trim_c;
  assign fuse_w[3] = fuse_trim_d;

  ////////////////////////////////////////////////////////////////////////////
  // serial port
  atsd_spi_slave u_spi (
    .clk     (clk),
    .srst    (srst),
    .sclk    (sclk),
    .scs_n   (scs_n),
    .sdi     (sdi),
    .rd_data (rd_data),
    .sdo     (sdo),
    .sdo_oe  (sdo_oe),
    .wr_stb  (wr_stb),
    .addr    (addr),
    .wdata   (wdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fuse preload: flag set by reset, so trims load on the first cycle
  // after release rather than sampling a port inside the reset branch
  always_comb begin
    fuse_ld_d = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (srst) fuse_ld_q <= 1'b1;
    else      fuse_ld_q <= fuse_ld_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination trims, one per analog input
  for (genvar g = 0; g < N_INPUTS; g++) begin : g_trim
    always_comb begin
      trim_d[g] = trim_q[g];
      if (fuse_ld_q) begin
        trim_d[g] = fuse_w[g];
      end else if (wr_stb && sel == atsd_sel_e'(g)) begin
        trim_d[g] = wdata;
      end
    end

    always_ff @(posedge clk) begin
      if (srst) trim_q[g] <= RST_TRIM;
      else      trim_q[g] <= trim_d[g];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // swap delays and dither control; reserved bits are not stored, since
  // software must write them as zero and they then read back as zero
  always_comb begin
    ovl_d   = ovl_q;
    steer_d = steer_q;
    dith_d  = dith_q;
    if (wr_stb) begin
      unique case (sel)
        // writes are not gated by calibration state; software owns that
        ATSD_SEL_OVL:   ovl_d   = wdata[DLY_W-1:0];
        ATSD_SEL_STEER: steer_d = wdata[DLY_W-1:0];
        ATSD_SEL_DITH:  dith_d  = wdata[DITH_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ovl_q   <= RST_OVL;
      steer_q <= RST_STEER;
      dith_q  <= RST_DITH;
    end else begin
      ovl_q   <= ovl_d;
      steer_q <= steer_d;
      dith_q  <= dith_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always_comb begin
    rd_data = '0;
    unique case (sel)
      ATSD_SEL_TRIM_A,
      ATSD_SEL_TRIM_B,
      ATSD_SEL_TRIM_C,
      ATSD_SEL_TRIM_D: rd_data = trim_q[sel[1:0]];
      ATSD_SEL_OVL:    rd_data = {3'h0, ovl_q};
      ATSD_SEL_STEER:  rd_data = {3'h0, steer_q};
      ATSD_SEL_DITH:   rd_data = {5'h00, dith_q};
      default:         rd_data = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // background swap timing
  atsd_swap_timer u_swap (
    .clk            (clk),
    .srst           (srst),
    .swap_start     (swap_start),
    .overlap_dly    (ovl_q),
    .steer_dly      (steer_q),
    .overlap_active (swap_overlap_active),
    .steer_sel      (steer_sel),
    .busy           (swap_busy)
  );

  // outputs straight from the register flops
  assign input_a_term_trim       = trim_q[0];
  assign input_b_term_trim       = trim_q[1];
  assign input_c_term_trim       = trim_q[2];
  assign input_d_term_trim       = trim_q[3];
  assign dither_enable           = dith_q[DITH_EN_BIT];
  assign dither_amplitude_select = dith_q[DITH_AMP_BIT];
  assign rounding_error_select   = dith_q[DITH_ERR_BIT];

endmodule : atsd_regs

`default_nettype wire

// ### test/atsd_regs_sva.sv
// atsd_regs_sva: port-level checks of the trim, swap-delay and dither bank.
// assumes it is bound to atsd_regs and sees only that module's ports.
`default_nettype none

module atsd_regs_chk
  import atsd_pkg::*;
(
  input wire logic              clk,                     // clock
  input wire logic              srst,                    // sync reset
  input wire logic              sclk,                    // serial clock
  input wire logic              scs_n,                   // select, low
  input wire logic              sdo,                     // serial out
  input wire logic              sdo_oe,                  // sdo enable
  input wire logic [DATA_W-1:0] fuse_trim_a,             // fuse a
  input wire logic [DATA_W-1:0] fuse_trim_b,             // fuse b
  input wire logic [DATA_W-1:0] fuse_trim_c,             // fuse c
  input wire logic [DATA_W-1:0] fuse_trim_d,             // fuse d
  input wire logic              swap_start,              // swap pulse
  input wire logic [DATA_W-1:0] input_a_term_trim,       // trim a
  input wire logic [DATA_W-1:0] input_b_term_trim,       // trim b
  input wire logic [DATA_W-1:0] input_c_term_trim,       // trim c
  input wire logic [DATA_W-1:0] input_d_term_trim,       // trim d
  input wire logic              dither_enable,           // dither bit 0
  input wire logic              dither_amplitude_select, // dither bit 1
  input wire logic              rounding_error_select,   // dither bit 2
  input wire logic              swap_overlap_active,     // overlap window
  input wire logic              steer_sel,               // steering select
  input wire logic              swap_busy                // swap running
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // overlap run length, counted so the window can be judged at its end
  logic [6:0] run_q;
  logic [6:0] run_d;
  always_comb begin
    run_d = swap_overlap_active ? run_q + 7'h01 : 7'h00;
  end
  always_ff @(posedge clk) begin
    run_q <= srst ? 7'h00 : run_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // swap timing; window is 4 plus twice a 0..31 field, so even and 4..66
  AST_SWAP_START: assert property (swap_start && !swap_busy |-> ##[1:2]
    (swap_busy && swap_overlap_active)) else $error("swap did not start");
  AST_OVL_CAUSE: assert property ($rose(swap_overlap_active) |->
    ($past(swap_start) || $past(swap_start, 2))) else $error("stray overlap window");
  AST_OVL_LEN: assert property ($fell(swap_overlap_active) |->
    (run_q >= 7'h04 && run_q <= 7'h42 && !run_q[0])) else $error("overlap length off");
  AST_OVL_BUSY: assert property (swap_overlap_active |-> swap_busy)
    else $error("overlap outside swap");
  AST_STEER_WIN: assert property (swap_start && !swap_busy |-> ##[2:34]
    $changed(steer_sel)) else $error("steering select late");
  AST_STEER_SWAP: assert property ($changed(steer_sel) |->
    (swap_busy || $past(swap_busy))) else $error("steering moved outside swap");

  ////////////////////////////////////////////////////////////////////////////
  // reset values, fuse preload and register stability
  AST_RST_VAL: assert property (disable iff (1'b0) srst |=>
    !(swap_busy || swap_overlap_active || steer_sel || sdo_oe || dither_enable ||
      dither_amplitude_select || rounding_error_select)) else $error("reset value off");
  AST_FUSE: assert property ($fell(srst) |-> ##[1:2]
    (input_a_term_trim == fuse_trim_a && input_b_term_trim == fuse_trim_b &&
     input_c_term_trim == fuse_trim_c && input_d_term_trim == fuse_trim_d))
    else $error("fuse trim not loaded");
  AST_TRIM_HOLD: assert property ($changed(input_a_term_trim) |->
    (!$past(scs_n, 3) || $past(srst, 2) || $past(srst, 3))) else $error("trim moved");
  AST_SDO_HOLD: assert property ($changed(sdo) && sdo_oe && $past(sdo_oe) |->
    !$past(sclk)) else $error("sdo moved while sclk high");
  AST_OE_DROP: assert property ($rose(scs_n) |-> ##[1:3] !sdo_oe)
    else $error("sdo still driven");

  // main scenarios seen
  CVR_SWAP: cover property (swap_start && !swap_busy);
  CVR_READ: cover property ($fell(sdo_oe));
  CVR_DITH: cover property ($rose(dither_enable));
endmodule : atsd_regs_chk

`default_nettype wire

// ### test/tb.sv
// tb: self-checking bench of the trim, swap-delay and dither bank.
// assumes atsd_pkg, the design files and atsd_regs_sva.sv compiled first.
`default_nettype none

`define CHK(n, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", n, e, g); \
    failures++; \
  end \
end

module tb
  import atsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk, srst, sclk, scs_n, sdi, sdo, sdo_oe, swap_start;
  logic              dither_enable, dither_amplitude_select, rounding_error_select;
  logic              swap_overlap_active, steer_sel, swap_busy;
  logic [DATA_W-1:0] fuse [4];
  logic [DATA_W-1:0] trim [4];
  logic [ADDR_W-1:0] tadr [4];
  int                failures, compares, cyc;

  atsd_regs dut (
    .clk, .srst, .sclk, .scs_n, .sdi, .sdo, .sdo_oe, .swap_start,
    .fuse_trim_a(fuse[0]), .fuse_trim_b(fuse[1]),
    .fuse_trim_c(fuse[2]), .fuse_trim_d(fuse[3]),
    .input_a_term_trim(trim[0]), .input_b_term_trim(trim[1]),
    .input_c_term_trim(trim[2]), .input_d_term_trim(trim[3]),
    .dither_enable, .dither_amplitude_select, .rounding_error_select,
    .swap_overlap_active, .steer_sel, .swap_busy
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; a whole run needs well under 20000 cycles
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // inputs move 1 ns after the edge so the design never races the bench
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  ////////////////////////////////////////////////////////////////////////////
  // one serial frame; sclk half period of 4 cycles keeps above the 2 minimum
  task automatic xfer(input logic rnw, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    logic [23:0] f;
    f = {rnw, a, wd};
    rd = 8'h00;
    scs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      tick(4);
      if (i < 8) rd = {rd[6:0], sdo};
      if (i == 0) `CHK("sdo_oe", rnw, sdo_oe)
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    scs_n = 1'b1;
    tick(2);
  endtask : xfer

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] x;
    xfer(1'b0, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] x;
    xfer(1'b1, a, 8'h00, x);
    `CHK("readback", e, x)
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      `CHK("trim_port", fuse[i], trim[i])
      rd_chk(tadr[i], fuse[i]);
    end
    rd_chk(ADDR_OVL, 8'h08);
    rd_chk(ADDR_STEER, 8'h07);
    rd_chk(ADDR_DITH, 8'h00);
  endtask : t_reset

  // all four written before any read, so crossed addresses show up
  task automatic t_trim();
    for (int i = 0; i < 4; i++) wr(tadr[i], ~fuse[i]);
    for (int i = 0; i < 4; i++) begin
      rd_chk(tadr[i], ~fuse[i]);
      `CHK("trim_port", ~fuse[i], trim[i])
    end
  endtask : t_trim

  // field limits and an unmapped hole between the delay and dither registers
  task automatic t_delay();
    wr(ADDR_OVL, 8'h1f);
    rd_chk(ADDR_OVL, 8'h1f);
    wr(ADDR_STEER, 8'h00);
    rd_chk(ADDR_STEER, 8'h00);
    wr(15'h009c, 8'h5a);
    rd_chk(15'h009c, 8'h00);
    rd_chk(ADDR_OVL, 8'h1f);
  endtask : t_delay

  task automatic t_dith();
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_DITH, 8'(v));
      `CHK("dith_en", v[0], dither_enable)
      `CHK("dith_amp", v[1], dither_amplitude_select)
      `CHK("dith_err", v[2], rounding_error_select)
      rd_chk(ADDR_DITH, 8'(v));
    end
  endtask : t_dith

  // a second request in mid-swap must be ignored
  task automatic t_swap(input int d, input int s);
    int   k, len, tog, ntog;
    logic st;
    wr(ADDR_OVL, 8'(d));
    wr(ADDR_STEER, 8'(s));
    st = steer_sel;
    swap_start = 1'b1;
    tick(1);
    swap_start = 1'b0;
    k = 0;
    len = 0;
    tog = 0;
    ntog = 0;
    // sampled from the cycle right after the start edge, so k counts edges
    while ((swap_busy || k < 2) && k < 200) begin
      if (swap_overlap_active) len++;
      if (steer_sel !== st) begin
        ntog++;
        tog = k;
        st = steer_sel;
      end
      tick(1);
      k++;
      swap_start = (k == 3);
    end
    `CHK("ovl_len", 4 + 2 * d, len)
    `CHK("steer_at", s + 1, tog)
    `CHK("steer_cnt", 1, ntog)
    `CHK("swap_busy", 1'b0, swap_busy)
  endtask : t_swap

  ////////////////////////////////////////////////////////////////////////////
  // main sequence, with a second reset to see defaults come back
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    sclk = 1'b0;
    scs_n = 1'b1;
    sdi = 1'b0;
    swap_start = 1'b0;
    fuse = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
    tadr = '{ADDR_TRIM_A, ADDR_TRIM_B, ADDR_TRIM_C, ADDR_TRIM_D};
    failures = 0;
    compares = 0;
    cyc = 0;
    tick(10);
    srst = 1'b0;
    tick(4);
    t_reset();
    t_trim();
    t_delay();
    t_dith();
    t_swap(0, 31);
    t_swap(31, 0);
    t_swap(7, 7);
    srst = 1'b1;
    tick(10);
    srst = 1'b0;
    tick(4);
    t_reset();
    end_sim();
  end
endmodule : tb

bind atsd_regs atsd_regs_chk u_chk (
  .clk, .srst, .sclk, .scs_n, .sdo, .sdo_oe, .swap_start,
  .fuse_trim_a, .fuse_trim_b, .fuse_trim_c, .fuse_trim_d,
  .input_a_term_trim, .input_b_term_trim, .input_c_term_trim, .input_d_term_trim,
  .dither_enable, .dither_amplitude_select, .rounding_error_select,
  .swap_overlap_active, .steer_sel, .swap_busy
);

`default_nettype wire
